// file: ps_cmd_pkg.sv
// constants and types shared by the parameter store command unit
package ps_cmd_pkg;

   // timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned SEC_TIME_S = 1;
   localparam int unsigned SEC_CYCLES = CLK_HZ * SEC_TIME_S;
   localparam int unsigned SAVE_TIME_MS = 200;
   localparam int unsigned SAVE_CYCLES = CLK_HZ / 1000 * SAVE_TIME_MS;

   // register indices; byte address is four times the index
   localparam int unsigned ADDR_W = 12;
   localparam logic [7:0] RETRY_IDX = 8'h5f;
   localparam logic [7:0] CMD_IDX = 8'h60;
   localparam logic [7:0] INFO_IDX = 8'h61;
   localparam logic [ADDR_W-1:0] RETRY_ADDR = {2'h0, RETRY_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] CMD_ADDR = {2'h0, CMD_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] INFO_ADDR = {2'h0, INFO_IDX, 2'h0};

   // reset values
   localparam logic [15:0] RETRY_RESET = 16'h0000;

   // command codes, 16-bit two's complement
   localparam logic [15:0] CODE_RESET = 16'hfffa;
   localparam logic [15:0] CODE_DLV_SAVE_MID = 16'hfffb;
   localparam logic [15:0] CODE_USER_MID = 16'hfffc;
   localparam logic [15:0] CODE_DLV_ERASE = 16'hfffd;
   localparam logic [15:0] CODE_USER = 16'hfffe;
   localparam logic [15:0] CODE_DLV = 16'hffff;
   localparam logic [15:0] CODE_SAVE = 16'h0001;

   // read-back of the command register
   localparam logic [15:0] STAT_OK = 16'h0000;
   localparam logic [15:0] STAT_BUSY = 16'h0001;
   localparam logic [15:0] STAT_FAIL = 16'h0002;

   // info register bit positions
   localparam int unsigned INFO_REJ_BIT = 0;
   localparam int unsigned INFO_MID_BIT = 1;
   localparam int unsigned INFO_RETRY_BIT = 2;
   localparam int unsigned INFO_GATE_BIT = 3;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SAVE_REQ, ST_SAVE_WAIT, ST_MID_REQ, ST_MID_RUN
   } seq_state_t;

endpackage

// file: safe_run_retry.sv
// seconds timer that repeats a failed safe-position run
module safe_run_retry #(
   parameter int unsigned SEC_CYCLES = ps_cmd_pkg::SEC_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // control
   input wire logic [15:0] interval,
   input wire logic safeRunFailed,
   input wire logic safeRunOk,
   // result
   output logic retryPulse,
   output logic pending
);
   localparam int unsigned PW = $clog2(SEC_CYCLES + 1);

   if (SEC_CYCLES < 1) begin : gSecCheck
      $error("SEC_CYCLES must be at least one");
   end

   logic [PW-1:0] prescale_reg;
   logic [15:0] secLeft_reg;
   logic secTick;

   assign secTick = (prescale_reg == PW'(SEC_CYCLES - 1));

   // one-cycle enable per second, restarted by each failure
   always_ff @(posedge clk) begin
      if (sys_rst || safeRunFailed || secTick)
         prescale_reg <= '0;
      else
         prescale_reg <= prescale_reg + PW'(1);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pending <= 1'b0;
         secLeft_reg <= 16'h0000;
         retryPulse <= 1'b0;
      end else begin
         retryPulse <= 1'b0;
         if (safeRunFailed) begin
            pending <= (interval != 16'h0000);
            secLeft_reg <= interval;
         end else if (safeRunOk) begin
            pending <= 1'b0;
         end else if (pending && secTick) begin
            if (secLeft_reg == 16'h0001) begin
               pending <= 1'b0;
               retryPulse <= 1'b1;
            end
            secLeft_reg <= secLeft_reg - 16'h0001;
         end
      end
   end

   a_retry_zero_off: assert property (@(posedge clk) disable iff (sys_rst)
      safeRunFailed && interval == 16'h0000 |=> !pending [*3])
      else $error("retry armed with zero interval");

   a_retry_armed: assert property (@(posedge clk) disable iff (sys_rst)
      safeRunFailed && interval != 16'h0000 |=> pending)
      else $error("failed safe run did not arm retry");

   a_retry_needs_pending: assert property (@(posedge clk) disable iff (sys_rst)
      retryPulse |-> $past(pending) && !pending)
      else $error("retry fired without being armed");
endmodule

// file: param_cmd_unit.sv
// parameter store command unit with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite register port.
module param_cmd_unit #(
   parameter int unsigned SEC_CYCLES = ps_cmd_pkg::SEC_CYCLES,
   parameter int unsigned SAVE_CYCLES = ps_cmd_pkg::SAVE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // drive state
   input wire logic standstill,
   input wire logic bootCheckDone,
   input wire logic bootCheckOk,
   input wire logic nvmDone,
   input wire logic nvmOk,
   input wire logic midRunDone,
   input wire logic safeRunFailed,
   input wire logic safeRunOk,
   input wire logic [15:0] controlWord,
   // parameter actions
   output logic driveResetReq,
   output logic loadDelivery,
   output logic loadUserSaved,
   output logic eraseIdentity,
   output logic nvmSaveReq,
   // motion
   output logic midRunStart,
   output logic midRunToPosRange,
   output logic midRunAbort,
   output logic controlGate,
   output logic safeRunRetry
);
   localparam int unsigned TW = $clog2(SAVE_CYCLES + 1);

   if (SAVE_CYCLES < 2) begin : gSaveCheck
      $error("SAVE_CYCLES must be at least two");
   end
   if (SEC_CYCLES < 1) begin : gSecCheck
      $error("SEC_CYCLES must be at least one");
   end

   // bus state
   logic wrPend_reg;
   logic [ps_cmd_pkg::ADDR_W-1:0] wrAddr_reg;
   logic addrPhase;

   // registers and sequencer
   logic [15:0] retryInterval_reg;
   logic [15:0] status_reg;
   logic rejected_reg;
   logic midAfterSave_reg;
   logic [15:0] cwHeld_reg;
   logic [TW-1:0] saveTimer_reg;
   ps_cmd_pkg::seq_state_t state_reg;

   logic cmdWrite;
   logic [15:0] cmdCode;
   logic legalCode;
   logic accept;
   logic retryPending;
   logic saveTimeout;

   assign addrPhase = hsel && htrans[1] && hready;
   assign cmdCode = hwdata[15:0];
   assign cmdWrite = wrPend_reg && (wrAddr_reg == ps_cmd_pkg::CMD_ADDR);
   assign saveTimeout = (saveTimer_reg == TW'(SAVE_CYCLES - 1));

   always_comb begin
      unique case (cmdCode)
         ps_cmd_pkg::CODE_RESET,
         ps_cmd_pkg::CODE_DLV_SAVE_MID,
         ps_cmd_pkg::CODE_USER_MID,
         ps_cmd_pkg::CODE_DLV_ERASE,
         ps_cmd_pkg::CODE_USER,
         ps_cmd_pkg::CODE_DLV,
         ps_cmd_pkg::CODE_SAVE: legalCode = 1'b1;
         default: legalCode = 1'b0;
      endcase
   end

   // only when stationary and not mid-sequence
   assign accept = cmdWrite && legalCode && standstill
      && (state_reg == ps_cmd_pkg::ST_IDLE);

   // zero-wait slave: every transfer finishes in one data phase
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= '0;
      end else begin
         // upper address bits must be clear, or a write would alias
         wrPend_reg <= addrPhase && hwrite
            && (haddr[31:ps_cmd_pkg::ADDR_W] == '0);
         wrAddr_reg <= haddr[ps_cmd_pkg::ADDR_W-1:0];
      end
   end

   // read data taken at the address phase; unmapped reads give zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (addrPhase && !hwrite) begin
         if (haddr[31:ps_cmd_pkg::ADDR_W] != '0)
            hrdata <= 32'h0000_0000;
         else begin
            unique case (haddr[ps_cmd_pkg::ADDR_W-1:0])
               ps_cmd_pkg::RETRY_ADDR: hrdata <= {16'h0000, retryInterval_reg};
               ps_cmd_pkg::CMD_ADDR: hrdata <= {16'h0000, status_reg};
               ps_cmd_pkg::INFO_ADDR: begin
                  hrdata <= 32'h0000_0000;
                  hrdata[ps_cmd_pkg::INFO_REJ_BIT] <= rejected_reg;
                  hrdata[ps_cmd_pkg::INFO_MID_BIT] <=
                     (state_reg == ps_cmd_pkg::ST_MID_RUN);
                  hrdata[ps_cmd_pkg::INFO_RETRY_BIT] <= retryPending;
                  hrdata[ps_cmd_pkg::INFO_GATE_BIT] <= controlGate;
               end
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // retry interval, writable at any time
   always_ff @(posedge clk) begin
      if (sys_rst)
         retryInterval_reg <= ps_cmd_pkg::RETRY_RESET;
      else if (wrPend_reg && wrAddr_reg == ps_cmd_pkg::RETRY_ADDR)
         retryInterval_reg <= hwdata[15:0];
   end

   // last command write refused; an accepted one clears it
   always_ff @(posedge clk) begin
      if (sys_rst)
         rejected_reg <= 1'b0;
      else if (cmdWrite)
         rejected_reg <= !accept;
   end

   // command sequencer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= ps_cmd_pkg::ST_IDLE;
         midAfterSave_reg <= 1'b0;
         midRunToPosRange <= 1'b0;
      end else begin
         unique case (state_reg)
            ps_cmd_pkg::ST_IDLE: begin
               if (accept) begin
                  midAfterSave_reg <= 1'b0;
                  unique case (cmdCode)
                     ps_cmd_pkg::CODE_DLV_SAVE_MID: begin
                        midAfterSave_reg <= 1'b1;
                        midRunToPosRange <= 1'b0;
                        state_reg <= ps_cmd_pkg::ST_SAVE_REQ;
                     end
                     ps_cmd_pkg::CODE_USER_MID: begin
                        midRunToPosRange <= 1'b1;
                        state_reg <= ps_cmd_pkg::ST_MID_REQ;
                     end
                     ps_cmd_pkg::CODE_DLV_ERASE,
                     ps_cmd_pkg::CODE_SAVE:
                        state_reg <= ps_cmd_pkg::ST_SAVE_REQ;
                     default: state_reg <= ps_cmd_pkg::ST_IDLE;
                  endcase
               end
            end
            ps_cmd_pkg::ST_SAVE_REQ: state_reg <= ps_cmd_pkg::ST_SAVE_WAIT;
            ps_cmd_pkg::ST_SAVE_WAIT: begin
               // mid-run only follows a successful save
               if (nvmDone)
                  state_reg <= (nvmOk && midAfterSave_reg) ?
                     ps_cmd_pkg::ST_MID_REQ : ps_cmd_pkg::ST_IDLE;
               else if (saveTimeout)
                  state_reg <= ps_cmd_pkg::ST_IDLE;
            end
            ps_cmd_pkg::ST_MID_REQ: state_reg <= ps_cmd_pkg::ST_MID_RUN;
            ps_cmd_pkg::ST_MID_RUN: begin
               if (controlWord != cwHeld_reg || midRunDone)
                  state_reg <= ps_cmd_pkg::ST_IDLE;
            end
            default: state_reg <= ps_cmd_pkg::ST_IDLE;
         endcase
      end
   end

   // one-cycle action pulses
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         driveResetReq <= 1'b0;
         loadDelivery <= 1'b0;
         loadUserSaved <= 1'b0;
         eraseIdentity <= 1'b0;
      end else begin
         driveResetReq <= accept && cmdCode == ps_cmd_pkg::CODE_RESET;
         loadDelivery <= accept && (cmdCode == ps_cmd_pkg::CODE_DLV_SAVE_MID
            || cmdCode == ps_cmd_pkg::CODE_DLV_ERASE
            || cmdCode == ps_cmd_pkg::CODE_DLV);
         loadUserSaved <= accept && (cmdCode == ps_cmd_pkg::CODE_USER_MID
            || cmdCode == ps_cmd_pkg::CODE_USER);
         eraseIdentity <= accept && cmdCode == ps_cmd_pkg::CODE_DLV_ERASE;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         nvmSaveReq <= 1'b0;
         midRunStart <= 1'b0;
         midRunAbort <= 1'b0;
      end else begin
         nvmSaveReq <= (state_reg == ps_cmd_pkg::ST_SAVE_REQ);
         midRunStart <= (state_reg == ps_cmd_pkg::ST_MID_REQ);
         midRunAbort <= (state_reg == ps_cmd_pkg::ST_MID_RUN)
            && (controlWord != cwHeld_reg);
      end
   end

   // save watchdog: no answer within the save time counts as failure
   always_ff @(posedge clk) begin
      if (sys_rst || state_reg != ps_cmd_pkg::ST_SAVE_WAIT)
         saveTimer_reg <= '0;
      else if (!saveTimeout)
         saveTimer_reg <= saveTimer_reg + TW'(1);
   end

   // memory status as read back through the command register
   always_ff @(posedge clk) begin
      if (sys_rst)
         status_reg <= ps_cmd_pkg::STAT_OK;
      else if (state_reg == ps_cmd_pkg::ST_SAVE_REQ)
         status_reg <= ps_cmd_pkg::STAT_BUSY;
      else if (state_reg == ps_cmd_pkg::ST_SAVE_WAIT) begin
         if (nvmDone)
            status_reg <= nvmOk ? ps_cmd_pkg::STAT_OK : ps_cmd_pkg::STAT_FAIL;
         else if (saveTimeout)
            status_reg <= ps_cmd_pkg::STAT_FAIL;
      end else if (bootCheckDone)
         status_reg <= bootCheckOk ? ps_cmd_pkg::STAT_OK :
            ps_cmd_pkg::STAT_FAIL;
   end

   // control-word gate: closed at mid-run start, opened only by a change,
   // so a standing run command is never replayed afterwards
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         controlGate <= 1'b1;
         cwHeld_reg <= 16'h0000;
      end else if (state_reg == ps_cmd_pkg::ST_MID_REQ) begin
         controlGate <= 1'b0;
         cwHeld_reg <= controlWord;
      end else if (!controlGate && controlWord != cwHeld_reg) begin
         controlGate <= 1'b1;
      end
   end

   safe_run_retry #(
      .SEC_CYCLES(SEC_CYCLES)
   ) retryTimer (
      .clk(clk),
      .sys_rst(sys_rst),
      .interval(retryInterval_reg),
      .safeRunFailed(safeRunFailed),
      .safeRunOk(safeRunOk),
      .retryPulse(safeRunRetry),
      .pending(retryPending)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_reset_cmd: assert property (
      accept && cmdCode == ps_cmd_pkg::CODE_RESET |=> driveResetReq
      && !loadDelivery && !loadUserSaved)
      else $error("reset code did not reset the drive");

   a_dlv_save_mid: assert property (
      accept && cmdCode == ps_cmd_pkg::CODE_DLV_SAVE_MID |=> loadDelivery
      && !eraseIdentity ##1 nvmSaveReq)
      else $error("delivery-save sequence wrong");

   a_user_mid: assert property (
      accept && cmdCode == ps_cmd_pkg::CODE_USER_MID |=> loadUserSaved
      ##1 midRunStart && midRunToPosRange && !nvmSaveReq)
      else $error("user restore did not start mid-run");

   a_erase_save: assert property (
      accept && cmdCode == ps_cmd_pkg::CODE_DLV_ERASE |=> loadDelivery
      && eraseIdentity ##1 nvmSaveReq ##1 !midRunStart [*3])
      else $error("erase sequence wrong");

   a_user_nosave: assert property (
      accept && cmdCode == ps_cmd_pkg::CODE_USER |=> loadUserSaved
      ##1 (!nvmSaveReq && !midRunStart) [*3])
      else $error("user restore touched memory or motion");

   a_dlv_nosave: assert property (
      accept && cmdCode == ps_cmd_pkg::CODE_DLV |=> loadDelivery
      && !eraseIdentity ##1 !nvmSaveReq [*3])
      else $error("delivery load saved memory");

   a_save_busy: assert property (
      accept && cmdCode == ps_cmd_pkg::CODE_SAVE |=> ##1 nvmSaveReq
      && status_reg == ps_cmd_pkg::STAT_BUSY)
      else $error("save did not start or status not busy");

   a_save_result: assert property (
      state_reg == ps_cmd_pkg::ST_SAVE_WAIT && nvmDone |=>
      status_reg == ($past(nvmOk) ? ps_cmd_pkg::STAT_OK :
      ps_cmd_pkg::STAT_FAIL))
      else $error("save result not reported");

   a_boot_corrupt: assert property (
      bootCheckDone && !bootCheckOk && state_reg == ps_cmd_pkg::ST_IDLE
      |=> status_reg != ps_cmd_pkg::STAT_OK)
      else $error("corrupt memory read back as valid");

   a_moving_refused: assert property (
      cmdWrite && !standstill |=> !driveResetReq && !loadDelivery
      && !loadUserSaved ##1 !nvmSaveReq && !midRunStart)
      else $error("command acted while moving");

   a_bad_code: assert property (
      cmdWrite && !legalCode |=> rejected_reg && !loadDelivery
      && !loadUserSaved && !driveResetReq)
      else $error("undefined code had an effect");

   a_cw_abort: assert property (
      state_reg == ps_cmd_pkg::ST_MID_RUN && controlWord != cwHeld_reg
      |=> midRunAbort && controlGate && state_reg == ps_cmd_pkg::ST_IDLE)
      else $error("control word change did not abort mid-run");

   a_gate_closed: assert property (
      midRunStart |-> !controlGate
      && cwHeld_reg == $past(controlWord))
      else $error("gate open at mid-run start");

   a_gate_stays: assert property (
      !controlGate && controlWord == cwHeld_reg
      && state_reg != ps_cmd_pkg::ST_MID_REQ |=> !controlGate)
      else $error("gate opened without control word change");
endmodule

// file: drive_side_model.sv
// drive-side model answering save requests and mid-range runs
module drive_side_model (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // requests from the unit
   input wire logic nvmSaveReq,
   input wire logic midRunStart,
   input wire logic midRunAbort,
   // behaviour chosen by the bench
   input wire logic [7:0] saveDelay,
   input wire logic saveGood,
   input wire logic [7:0] runDelay,
   // answers
   output logic nvmDone,
   output logic nvmOk,
   output logic midRunDone
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] saveCnt;
   logic [7:0] runCnt;
   logic saveBusy;
   logic runBusy;
   // delay ff never answers, so the unit has to give up on its own
   always_ff @(posedge clk) begin
      nvmDone <= 1'b0;
      nvmOk <= ~nvmOk;
      if (sys_rst) begin
         saveBusy <= 1'b0;
         saveCnt <= 8'h00;
         nvmOk <= 1'b0;
      end else if (nvmSaveReq) begin
         saveBusy <= (saveDelay != 8'hff);
         saveCnt <= saveDelay;
      end else if (saveBusy) begin
         if (saveCnt == 8'h00) begin
            nvmDone <= 1'b1;
            nvmOk <= saveGood;
            saveBusy <= 1'b0;
         end else begin
            saveCnt <= saveCnt - 8'h01;
         end
      end
   end
   // an abort stops the run with no done pulse
   always_ff @(posedge clk) begin
      midRunDone <= 1'b0;
      if (sys_rst || midRunAbort) begin
         runBusy <= 1'b0;
         runCnt <= 8'h00;
      end else if (midRunStart) begin
         runBusy <= 1'b1;
         runCnt <= runDelay;
      end else if (runBusy) begin
         if (runCnt == 8'h00) begin
            midRunDone <= 1'b1;
            runBusy <= 1'b0;
         end else begin
            runCnt <= runCnt - 8'h01;
         end
      end
   end
endmodule

// file: test_param_cmd_unit.sv
// self-checking bench for the parameter store command unit
module test_param_cmd_unit;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned SECS = 20;
   localparam int unsigned SAVES = 50;
   logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic standstill, bootCheckDone, bootCheckOk, nvmDone, nvmOk;
   logic midRunDone, safeRunFailed, safeRunOk, saveGood;
   logic [15:0] controlWord, c;
   logic [7:0] saveDelay, runDelay, pv;
   logic driveResetReq, loadDelivery, loadUserSaved, eraseIdentity;
   logic nvmSaveReq, midRunStart, midRunToPosRange, midRunAbort;
   logic controlGate, safeRunRetry;
   int pc[8], snap[8], n, err_count = 0, samples_checked = 0, cycles = 0;
   int seed;
   logic [15:0] codes[7] = '{ps_cmd_pkg::CODE_RESET, ps_cmd_pkg::CODE_DLV,
      ps_cmd_pkg::CODE_USER, ps_cmd_pkg::CODE_DLV_ERASE,
      ps_cmd_pkg::CODE_SAVE, ps_cmd_pkg::CODE_DLV_SAVE_MID,
      ps_cmd_pkg::CODE_USER_MID};

   param_cmd_unit #(.SEC_CYCLES(SECS), .SAVE_CYCLES(SAVES)) uut (
      .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .standstill(standstill),
      .bootCheckDone(bootCheckDone), .bootCheckOk(bootCheckOk),
      .nvmDone(nvmDone), .nvmOk(nvmOk), .midRunDone(midRunDone),
      .safeRunFailed(safeRunFailed), .safeRunOk(safeRunOk),
      .controlWord(controlWord), .driveResetReq(driveResetReq),
      .loadDelivery(loadDelivery), .loadUserSaved(loadUserSaved),
      .eraseIdentity(eraseIdentity), .nvmSaveReq(nvmSaveReq),
      .midRunStart(midRunStart), .midRunToPosRange(midRunToPosRange),
      .midRunAbort(midRunAbort), .controlGate(controlGate),
      .safeRunRetry(safeRunRetry));
   drive_side_model far (
      .clk(clk), .sys_rst(sys_rst), .nvmSaveReq(nvmSaveReq),
      .midRunStart(midRunStart), .midRunAbort(midRunAbort),
      .saveDelay(saveDelay), .saveGood(saveGood), .runDelay(runDelay),
      .nvmDone(nvmDone), .nvmOk(nvmOk), .midRunDone(midRunDone));

   assign hready = hreadyout;
   assign pv = {safeRunRetry, midRunAbort, midRunStart, nvmSaveReq,
      eraseIdentity, loadUserSaved, loadDelivery, driveResetReq};

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // pulse counters; a stuck pulse shows up as a count above one
   always @(posedge clk) begin
      cycles++;
      for (int i = 0; i < 8; i++) if (pv[i] === 1'b1) pc[i]++;
      if (cycles == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one single transfer; read data taken at the data-phase edge
   task automatic ahb(input logic wr, input logic [31:0] a, wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      check("bus response", {31'h0, hresp}, 32'h0);
   endtask

   function automatic logic [7:0] exp_pulses(input logic [15:0] k, g);
      case (k)
         ps_cmd_pkg::CODE_RESET: return 8'h01;
         ps_cmd_pkg::CODE_DLV_SAVE_MID: return g ? 8'h32 : 8'h12;
         ps_cmd_pkg::CODE_USER_MID: return 8'h24;
         ps_cmd_pkg::CODE_DLV_ERASE: return 8'h1a;
         ps_cmd_pkg::CODE_USER: return 8'h04;
         ps_cmd_pkg::CODE_DLV: return 8'h02;
         ps_cmd_pkg::CODE_SAVE: return 8'h10;
         default: return 8'h00;
      endcase
   endfunction

   task automatic pulses(input logic [7:0] e);
      for (int i = 0; i < 8; i++) check("pulse count", pc[i] - snap[i], e[i]);
   endtask

   task automatic cmd(input logic [15:0] k, input logic g);
      logic [7:0] e;
      e = exp_pulses(k, g);
      saveGood <= g;
      snap = pc;
      ahb(1'b1, ps_cmd_pkg::CMD_ADDR, {16'h0, k});
      repeat (60) @(posedge clk);
      pulses(e);
      ahb(1'b0, ps_cmd_pkg::INFO_ADDR, 32'h0);
      check("reject flag", rd[0], exp_pulses(k, 1'b1) == 8'h00);
      ahb(1'b0, ps_cmd_pkg::CMD_ADDR, 32'h0);
      if (e[4]) check("save status", rd, g ? 32'h0 : 32'h2);
      if (e[5]) begin
         check("gate after run", controlGate, 1'b0);
         check("range", midRunToPosRange, k == codes[6]);
         controlWord <= controlWord + 16'h0001;
         repeat (2) @(posedge clk);
         check("gate reopened", controlGate, 1'b1);
      end
      $display("end of command %h", k);
   endtask

   initial begin
      seed = 41200;
      sys_rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      standstill = 1'b1;
      bootCheckDone = 1'b0;
      bootCheckOk = 1'b0;
      safeRunFailed = 1'b0;
      safeRunOk = 1'b0;
      controlWord = 16'h0014;
      saveDelay = 8'h0a;
      runDelay = 8'h0a;
      saveGood = 1'b1;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      check("gate at reset", controlGate, 1'b1);
      check("ready at reset", hreadyout, 1'b1);
      ahb(1'b0, ps_cmd_pkg::RETRY_ADDR, 32'h0);
      check("interval reset", rd, 32'h0);
      // boot check, corrupt then valid
      for (int ok = 0; ok < 2; ok++) begin
         bootCheckDone <= 1'b1;
         bootCheckOk <= ok[0];
         @(posedge clk);
         bootCheckDone <= 1'b0;
         @(posedge clk);
         ahb(1'b0, ps_cmd_pkg::CMD_ADDR, 32'h0);
         check("boot status", rd, ok ? 32'h0 : 32'h2);
      end
      $display("end of boot");
      // unmapped place: write ignored, reads zero
      ahb(1'b1, 32'h0000_117c, 32'h0000_1234);
      ahb(1'b0, 32'h0000_117c, 32'h0);
      check("unmapped read", rd, 32'h0);
      ahb(1'b0, ps_cmd_pkg::RETRY_ADDR, 32'h0);
      check("unmapped write", rd, 32'h0);
      for (int i = 0; i < 7; i++) cmd(codes[i], 1'b1);
      cmd(ps_cmd_pkg::CODE_DLV_SAVE_MID, 1'b0);
      for (int i = 0; i < 5; i++) begin
         c = 16'($random(seed));
         while (exp_pulses(c, 1'b1) != 8'h00) c = c + 16'h0002;
         controlWord <= 16'($random(seed));
         cmd(c, 1'b1);
      end
      // refused away from standstill
      standstill <= 1'b0;
      cmd(16'h0000, 1'b1);
      snap = pc;
      ahb(1'b1, ps_cmd_pkg::CMD_ADDR, {16'h0, ps_cmd_pkg::CODE_DLV});
      repeat (5) @(posedge clk);
      pulses(8'h00);
      ahb(1'b0, ps_cmd_pkg::INFO_ADDR, 32'h0);
      check("standstill refusal", rd[0], 1'b1);
      standstill <= 1'b1;
      // save in progress, then a save that never finishes
      saveDelay <= 8'h28;
      ahb(1'b1, ps_cmd_pkg::CMD_ADDR, {16'h0, ps_cmd_pkg::CODE_SAVE});
      repeat (4) @(posedge clk);
      ahb(1'b0, ps_cmd_pkg::CMD_ADDR, 32'h0);
      check("saving status", rd, 32'h1);
      ahb(1'b1, ps_cmd_pkg::CMD_ADDR, {16'h0, ps_cmd_pkg::CODE_DLV});
      ahb(1'b0, ps_cmd_pkg::INFO_ADDR, 32'h0);
      check("busy refusal", rd[0], 1'b1);
      repeat (60) @(posedge clk);
      saveDelay <= 8'hff;
      cmd(ps_cmd_pkg::CODE_SAVE, 1'b0);
      saveDelay <= 8'h0a;
      // control word change aborts a mid-range run
      runDelay <= 8'h50;
      snap = pc;
      ahb(1'b1, ps_cmd_pkg::CMD_ADDR, {16'h0, ps_cmd_pkg::CODE_USER_MID});
      repeat (6) @(posedge clk);
      check("positioning range", midRunToPosRange, 1'b1);
      ahb(1'b0, ps_cmd_pkg::INFO_ADDR, 32'h0);
      check("mid-run info", rd[3:1], 3'b001);
      controlWord <= controlWord ^ 16'h0001;
      repeat (4) @(posedge clk);
      pulses(8'h64);
      check("gate after abort", controlGate, 1'b1);
      runDelay <= 8'h0a;
      $display("end of abort");
      // repeated safe-position runs
      for (int k = 0; k < 3; k++) begin
         n = (k == 0) ? 0 : int'($unsigned($random(seed)) % 3) + 1;
         ahb(1'b1, ps_cmd_pkg::RETRY_ADDR, n);
         ahb(1'b0, ps_cmd_pkg::RETRY_ADDR, 32'h0);
         check("interval readback", rd, n);
         snap = pc;
         safeRunFailed <= 1'b1;
         @(posedge clk);
         safeRunFailed <= 1'b0;
         safeRunOk <= (k == 2);
         @(posedge clk);
         safeRunOk <= 1'b0;
         ahb(1'b0, ps_cmd_pkg::INFO_ADDR, 32'h0);
         check("retry pending", rd[2], k == 1);
         repeat (n * SECS + 20) @(posedge clk);
         check("retry count", pc[7] - snap[7], k == 1);
      end
      $display("end of retry");
      tally_and_finish();
   end
endmodule
